// file: src/pllcfg_defs.svh
// Offsets, field positions and reset values of the PLL configuration bank
`ifndef PLLCFG_DEFS_SVH
`define PLLCFG_DEFS_SVH
`define PLLCFG_OFF_LOOP 4'h0
`define PLLCFG_OFF_REFDIV 4'h1
`define PLLCFG_OFF_FBDIV 4'h2
`define PLLCFG_OFF_STATCTL 4'h3
`define PLLCFG_LOOP_CAP_HI 9
`define PLLCFG_LOOP_CAP_LO 7
`define PLLCFG_LOOP_RES_HI 6
`define PLLCFG_LOOP_RES_LO 4
`define PLLCFG_PUMP_HI 3
`define PLLCFG_PUMP_LO 1
`define PLLCFG_FIXED_ONE 0
`define PLLCFG_LOOP_MASK 16'h03fe
`define PLLCFG_REFDIV_HI 15
`define PLLCFG_REFDIV_LO 2
`define PLLCFG_FBA_UP_HI 1
`define PLLCFG_FBA_UP_LO 0
`define PLLCFG_FBA_LOW_HI 15
`define PLLCFG_FBA_LOW_LO 8
`define PLLCFG_FBB_HI 7
`define PLLCFG_FBB_LO 0
`define PLLCFG_STATCTL_MASK 16'h1fff
`define PLLCFG_B_REFSEL 12
`define PLLCFG_B_REFLOSS 11
`define PLLCFG_B_LOCK 10
`define PLLCFG_A_REFSEL 9
`define PLLCFG_A_REFLOSS 8
`define PLLCFG_A_LOCK 7
`define PLLCFG_SOFT_RST 6
`define PLLCFG_SYNC 5
`define PLLCFG_CAL_EN 4
`define PLLCFG_PS_OUT_HI 3
`define PLLCFG_PS_OUT_LO 2
`define PLLCFG_PS_FB_HI 1
`define PLLCFG_PS_FB_LO 0
`define PLLCFG_RST_LOOP 16'h0001
`define PLLCFG_RST_REFDIV 16'h0000
`define PLLCFG_RST_FBDIV 16'h0000
`define PLLCFG_RST_STATCTL 16'h0000
`endif

// file: src/pllcfg_pkg.sv
// Types shared by the PLL configuration bank
package pllcfg_pkg;
  typedef logic [15:0] pllcfg_word_t;
  typedef logic [1:0] pllcfg_ps_t;
  typedef logic [3:0] pllcfg_addr_t;
endpackage

// file: src/pllcfg_stat_if.sv
// Status routing signals between the bank and its pin mux
`timescale 1ns/10ps
interface pllcfg_stat_if;
  logic [2:0] enable_a;
  logic [2:0] enable_b;
  logic [2:0] events;
  logic pin_a;
  logic pin_b;
  modport bank (output enable_a, output enable_b, output events, input pin_a, input pin_b);
  modport mux (input enable_a, input enable_b, input events, output pin_a, output pin_b);
endinterface

// file: src/pllcfg_stat_mux.sv
// Status pin routing of the three PLL indications
`timescale 1ns/10ps
module pllcfg_stat_mux (
  input wire clock,
  input wire rst,
  pllcfg_stat_if.mux st
);
  function automatic logic route(input logic [2:0] en, input logic [2:0] ev);
    route = |(en & ev);
  endfunction
  always_ff @(posedge clock) begin
    if (rst) begin
      st.pin_a <= 1'b0;
      st.pin_b <= 1'b0;
    end else begin
      st.pin_a <= route(st.enable_a, st.events);
      st.pin_b <= route(st.enable_b, st.events);
    end
  end
endmodule

// file: src/pllcfg_bank.sv
// Configuration register bank of the synthesizer PLL core
// What this block does
// - Register 0 bit 0 is tied to one and the host should write one there.
// - Register 0 bits 9:7 hold the loop capacitor code, 000 smallest.
// - Register 0 bits 6:4 hold the loop resistor code, 000 lowest, 111 highest.
// - Register 0 bits 3:1 hold the pump current code, rising with the code.
// - Register 1 bits 15:2 hold the 14-bit reference divider, ratio value plus one.
// - The 10-bit first feedback divider joins reg 1 bits 1:0 above reg 2 bits 15:8.
// - Register 2 bits 7:0 hold the 8-bit second feedback divider, ratio plus one.
// - Register 3 bits 12, 11, 10 enable refsel, refloss and lock on status pin b.
// - Register 3 bits 9, 8, 7 enable refsel, refloss and lock on status pin a.
// - Register 3 bit 6 at zero holds the core in reset keeping register contents.
// - Register 3 bit 5 at zero forces the output dividers into synchronization.
// - Register 3 bits 3:2 set the output prescaler to 4, 5 or 6; code 11 is reserved.
// - Register 3 bits 1:0 set the feedback prescaler to 4, 5 or 6; code 11 is reserved.
// - Each register is 16 bits, moved as two bytes high byte first.
`timescale 1ns/10ps
`include "pllcfg_defs.svh"
module pllcfg_bank import pllcfg_pkg::*; (
  input wire clock,
  input wire rst,
  input wire byte_valid,
  input wire [7:0] byte_data,
  input wire frame_start,
  input wire [3:0] frame_addr,
  input wire read_req,
  input wire [3:0] read_addr,
  input wire ev_refsel,
  input wire ev_refloss,
  input wire ev_lock,
  output logic [15:0] read_data,
  output logic read_valid,
  output logic [2:0] loop_cap_select,
  output logic [2:0] loop_res_select,
  output logic [2:0] pump_current_select,
  output logic [13:0] reference_divide_value,
  output logic [9:0] feedback_divide_a_value,
  output logic [7:0] feedback_divide_b_value,
  output logic core_reset_hold,
  output logic divider_sync_force,
  output logic calibration_enable,
  output logic [2:0] prescaler_outputs_ratio,
  output logic [2:0] prescaler_feedback_ratio,
  output logic status_pin_a,
  output logic status_pin_b
);
  typedef enum logic [1:0] {
    PLLCFG_HIGH = 2'b01,
    PLLCFG_LOW = 2'b10
  } pllcfg_phase_e;

  // Output reset values come from the register reset words, so the two cannot drift apart
  localparam pllcfg_word_t RST_LOOP_W = `PLLCFG_RST_LOOP;
  localparam pllcfg_word_t RST_REFDIV_W = `PLLCFG_RST_REFDIV;
  localparam pllcfg_word_t RST_FBDIV_W = `PLLCFG_RST_FBDIV;
  localparam pllcfg_word_t RST_STATCTL_W = `PLLCFG_RST_STATCTL;

  pllcfg_word_t loop_reg, refdiv_reg, fbdiv_reg, statctl_reg;
  pllcfg_phase_e phase_reg;
  pllcfg_addr_t addr_reg;
  logic [7:0] hi_byte_reg;
  logic wr_pulse;
  pllcfg_word_t wr_word;

  pllcfg_stat_if st ();

  // Reserved prescaler code mapped to divide-by-six rather than an undefined ratio
  function automatic logic [2:0] ps_ratio(input pllcfg_ps_t code);
    case (code)
      2'h0: ps_ratio = 3'h4;
      2'h1: ps_ratio = 3'h5;
      default: ps_ratio = 3'h6;
    endcase
  endfunction

  // Write strobe of one register, shared by all four holding flops
  function automatic logic wr_hit(input pllcfg_addr_t a, input pllcfg_addr_t off,
      input logic p);
    wr_hit = p && (a == off);
  endfunction

  function automatic pllcfg_word_t reg_view(input pllcfg_addr_t a,
      input pllcfg_word_t l, input pllcfg_word_t r, input pllcfg_word_t f,
      input pllcfg_word_t s);
    case (a)
      `PLLCFG_OFF_LOOP: reg_view = l | `PLLCFG_RST_LOOP;
      `PLLCFG_OFF_REFDIV: reg_view = r;
      `PLLCFG_OFF_FBDIV: reg_view = f;
      `PLLCFG_OFF_STATCTL: reg_view = s;
      default: reg_view = 16'h0000;
    endcase
  endfunction

  // Byte pairing; auto increment after each word like the serial block mode
  // An odd byte still pending at frame start is dropped, never written
  always_ff @(posedge clock) begin
    if (rst) begin
      phase_reg <= PLLCFG_HIGH;
      addr_reg <= 4'h0;
      hi_byte_reg <= 8'h00;
    end else if (frame_start) begin
      phase_reg <= PLLCFG_HIGH;
      addr_reg <= frame_addr;
    end else if (byte_valid) begin
      case (phase_reg)
        PLLCFG_HIGH: begin
          hi_byte_reg <= byte_data;
          phase_reg <= PLLCFG_LOW;
        end
        PLLCFG_LOW: begin
          phase_reg <= PLLCFG_HIGH;
          addr_reg <= addr_reg + 4'h1;
        end
        default: phase_reg <= PLLCFG_HIGH;
      endcase
    end
  end

  assign wr_pulse = byte_valid && !frame_start && (phase_reg == PLLCFG_LOW);
  assign wr_word = {hi_byte_reg, byte_data};

  // Reserved bits are masked so a careless write cannot reach them
  always_ff @(posedge clock) begin
    if (rst) begin
      loop_reg <= `PLLCFG_RST_LOOP;
    end else if (wr_hit(addr_reg, `PLLCFG_OFF_LOOP, wr_pulse)) begin
      loop_reg <= (wr_word & `PLLCFG_LOOP_MASK) | `PLLCFG_RST_LOOP;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      refdiv_reg <= `PLLCFG_RST_REFDIV;
    end else if (wr_hit(addr_reg, `PLLCFG_OFF_REFDIV, wr_pulse)) begin
      refdiv_reg <= wr_word;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      fbdiv_reg <= `PLLCFG_RST_FBDIV;
    end else if (wr_hit(addr_reg, `PLLCFG_OFF_FBDIV, wr_pulse)) begin
      fbdiv_reg <= wr_word;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      statctl_reg <= `PLLCFG_RST_STATCTL;
    end else if (wr_hit(addr_reg, `PLLCFG_OFF_STATCTL, wr_pulse)) begin
      statctl_reg <= wr_word & `PLLCFG_STATCTL_MASK;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      read_data <= 16'h0000;
      read_valid <= 1'b0;
    end else begin
      read_valid <= read_req;
      if (read_req) begin
        read_data <=
            reg_view(read_addr, loop_reg, refdiv_reg, fbdiv_reg, statctl_reg);
      end
    end
  end

  // Field outputs registered once more so every port leaves a flip-flop
  always_ff @(posedge clock) begin
    if (rst) begin
      loop_cap_select <= RST_LOOP_W[`PLLCFG_LOOP_CAP_HI:`PLLCFG_LOOP_CAP_LO];
      loop_res_select <= RST_LOOP_W[`PLLCFG_LOOP_RES_HI:`PLLCFG_LOOP_RES_LO];
      pump_current_select <= RST_LOOP_W[`PLLCFG_PUMP_HI:`PLLCFG_PUMP_LO];
    end else begin
      loop_cap_select <= loop_reg[`PLLCFG_LOOP_CAP_HI:`PLLCFG_LOOP_CAP_LO];
      loop_res_select <= loop_reg[`PLLCFG_LOOP_RES_HI:`PLLCFG_LOOP_RES_LO];
      pump_current_select <= loop_reg[`PLLCFG_PUMP_HI:`PLLCFG_PUMP_LO];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      reference_divide_value <= RST_REFDIV_W[`PLLCFG_REFDIV_HI:`PLLCFG_REFDIV_LO];
      feedback_divide_a_value <= {RST_REFDIV_W[`PLLCFG_FBA_UP_HI:`PLLCFG_FBA_UP_LO],
          RST_FBDIV_W[`PLLCFG_FBA_LOW_HI:`PLLCFG_FBA_LOW_LO]};
      feedback_divide_b_value <= RST_FBDIV_W[`PLLCFG_FBB_HI:`PLLCFG_FBB_LO];
    end else begin
      reference_divide_value <= refdiv_reg[`PLLCFG_REFDIV_HI:`PLLCFG_REFDIV_LO];
      feedback_divide_a_value <= {refdiv_reg[`PLLCFG_FBA_UP_HI:`PLLCFG_FBA_UP_LO],
          fbdiv_reg[`PLLCFG_FBA_LOW_HI:`PLLCFG_FBA_LOW_LO]};
      feedback_divide_b_value <= fbdiv_reg[`PLLCFG_FBB_HI:`PLLCFG_FBB_LO];
    end
  end

  // Soft reset only holds the core; the register words above are left untouched
  always_ff @(posedge clock) begin
    if (rst) begin
      core_reset_hold <= !RST_STATCTL_W[`PLLCFG_SOFT_RST];
      divider_sync_force <= !RST_STATCTL_W[`PLLCFG_SYNC];
      calibration_enable <= RST_STATCTL_W[`PLLCFG_CAL_EN];
      prescaler_outputs_ratio <= ps_ratio(RST_STATCTL_W[`PLLCFG_PS_OUT_HI:`PLLCFG_PS_OUT_LO]);
      prescaler_feedback_ratio <= ps_ratio(RST_STATCTL_W[`PLLCFG_PS_FB_HI:`PLLCFG_PS_FB_LO]);
    end else begin
      core_reset_hold <= !statctl_reg[`PLLCFG_SOFT_RST];
      divider_sync_force <= !statctl_reg[`PLLCFG_SYNC];
      calibration_enable <= statctl_reg[`PLLCFG_CAL_EN];
      prescaler_outputs_ratio <=
          ps_ratio(statctl_reg[`PLLCFG_PS_OUT_HI:`PLLCFG_PS_OUT_LO]);
      prescaler_feedback_ratio <=
          ps_ratio(statctl_reg[`PLLCFG_PS_FB_HI:`PLLCFG_PS_FB_LO]);
    end
  end

  // Enable bit k sits k places above the lock enable, matching the event bus order
  for (genvar k = 0; k < 3; k++) begin : g_enable
    assign st.enable_a[k] = statctl_reg[`PLLCFG_A_LOCK + k];
    assign st.enable_b[k] = statctl_reg[`PLLCFG_B_LOCK + k];
  end
  assign st.events = {ev_refsel, ev_refloss, ev_lock};
  assign status_pin_a = st.pin_a;
  assign status_pin_b = st.pin_b;

  pllcfg_stat_mux u_mux (
    .clock(clock),
    .rst(rst),
    .st(st)
  );
endmodule

// file: dv/pllcfg_assertions.sv
// Port checks of the PLL configuration bank
`timescale 1ns/10ps
module pllcfg_assertions (
  input wire clock,
  input wire rst,
  input wire byte_valid,
  input wire read_req,
  input wire [3:0] read_addr,
  input wire [15:0] read_data,
  input wire read_valid,
  input wire ev_refsel,
  input wire ev_refloss,
  input wire ev_lock,
  input wire [2:0] loop_cap_select,
  input wire [13:0] reference_divide_value,
  input wire core_reset_hold,
  input wire divider_sync_force,
  input wire [2:0] prescaler_feedback_ratio,
  input wire status_pin_a,
  input wire status_pin_b
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  read_answer_a: assert property (read_valid == $past(read_req))
    else $error("read answer not one cycle after request");
  fixed_one_a: assert property (read_valid && $past(read_addr) == 4'h0 |->
    read_data[15:10] == 6'h00 && read_data[0]) else $error("loop word reserved bits wrong");
  stat_reserved_a: assert property (read_valid && $past(read_addr) == 4'h3 |->
    read_data[15:13] == 3'h0) else $error("status word reserved bits wrong");
  unmapped_read_a: assert property (read_valid && $past(read_addr) > 4'h3 |->
    read_data == 16'h0000) else $error("unmapped read not zero");
  ratio_range_a: assert property (prescaler_feedback_ratio inside {3'h4, 3'h5, 3'h6})
    else $error("feedback ratio out of range");
  pins_quiet_a: assert property ((!(ev_refsel || ev_refloss || ev_lock)) [*2] |->
    !status_pin_a && !status_pin_b) else $error("status pin high without event");
  fields_hold_a: assert property (!byte_valid [*2] |=> $stable(loop_cap_select) &&
    $stable(reference_divide_value)) else $error("field moved without write");
  reset_state_a: assert property (disable iff (1'b0) rst [*3] |-> core_reset_hold &&
    divider_sync_force && prescaler_feedback_ratio == 3'h4) else $error("reset state wrong");
endmodule

// file: dv/pllcfg_host.sv
// Host model issuing write frames and reads
`timescale 1ns/10ps
module pllcfg_host (
  input wire clock,
  output logic frame_start,
  output logic [3:0] frame_addr,
  output logic byte_valid,
  output logic [7:0] byte_data,
  output logic read_req,
  output logic [3:0] read_addr,
  input wire [15:0] read_data,
  input wire read_valid
);
  initial {frame_start, frame_addr, byte_valid, byte_data, read_req, read_addr} = '0;
  task automatic wr(input logic [3:0] a, input logic [15:0] w);
    logic [15:0] v;
    v = (a == 4'h0) ? ((w & 16'h03fe) | 16'h0001) : w;
    if (a == 4'h3) v = w & 16'h1fff;
    @(posedge clock);
    frame_start <= 1'b1;
    frame_addr <= a;
    @(posedge clock);
    frame_start <= 1'b0;
    byte_valid <= 1'b1;
    byte_data <= v[15:8];
    @(posedge clock);
    byte_data <= v[7:0];
    @(posedge clock);
    byte_valid <= 1'b0;
    byte_data <= ~v[7:0];
    repeat (2) @(posedge clock);
    #1;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d, output logic ok);
    d = 16'hxxxx;
    ok = 1'b0;
    @(posedge clock);
    read_req <= 1'b1;
    read_addr <= a;
    @(posedge clock);
    read_req <= 1'b0;
    read_addr <= ~a;
    // Bounded wait, a hang leaves d unknown
    for (int i = 0; i < 4; i++) begin
      #1;
      if (read_valid === 1'b1) begin
        d = read_data;
        ok = 1'b1;
        break;
      end
      @(posedge clock);
    end
  endtask
endmodule

// file: dv/testbench.sv
// Self-checking bench of the PLL configuration bank
`timescale 1ns/10ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
  $display("mismatch %s expected %h seen %h", n, e, g); end end
module testbench;
  logic clock, rst, frame_start, byte_valid, read_req, read_valid, ev_refsel, ev_refloss, ev_lock;
  logic core_reset_hold, divider_sync_force, calibration_enable, status_pin_a, status_pin_b;
  logic [3:0] frame_addr, read_addr;
  logic [7:0] byte_data, feedback_divide_b_value;
  logic [15:0] read_data;
  logic [2:0] loop_cap_select, loop_res_select, pump_current_select;
  logic [2:0] prescaler_outputs_ratio, prescaler_feedback_ratio;
  logic [13:0] reference_divide_value;
  logic [9:0] feedback_divide_a_value;
  int checked = 0;
  int fails = 0;
  pllcfg_bank i_dut (.*);
  pllcfg_host i_host (.*);
  initial clock = 1'b0;
  always #25 clock = ~clock;
  task automatic rchk(input logic [3:0] a, input logic [15:0] e);
    logic [15:0] d;
    logic ok;
    i_host.rd(a, d, ok);
    if (ok !== 1'b1) begin
      fails++;
      $display("mismatch read_valid expected 1 seen 0");
      final_report;
    end else begin
      `CHK("read_data", e, d)
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    {ev_refsel, ev_refloss, ev_lock} = 3'h0;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    #1;
    `CHK("hold", 1'b1, core_reset_hold)
    `CHK("sync", 1'b1, divider_sync_force)
    rchk(4'h0, 16'h0001);
    rchk(4'h5, 16'h0000);
    $display("test reset done");
    i_host.wr(4'h0, 16'h0354);
    rchk(4'h0, 16'h0355);
    `CHK("cap", 3'h6, loop_cap_select)
    `CHK("res", 3'h5, loop_res_select)
    `CHK("pump", 3'h2, pump_current_select)
    i_host.wr(4'h1, 16'habcd);
    i_host.wr(4'h2, 16'h5e71);
    rchk(4'h1, 16'habcd);
    rchk(4'h2, 16'h5e71);
    `CHK("ref", 14'h2af3, reference_divide_value)
    `CHK("fba", 10'h15e, feedback_divide_a_value)
    `CHK("fbb", 8'h71, feedback_divide_b_value)
    $display("test dividers done");
    // Code 11 is never sent, only 00, 01 and 10
    for (int c = 0; c < 3; c++) begin
      i_host.wr(4'h3, 16'h0070 | 16'(c << 2) | 16'(2 - c));
      `CHK("ps_out", 3'(4 + c), prescaler_outputs_ratio)
      `CHK("ps_fb", 3'(6 - c), prescaler_feedback_ratio)
      `CHK("cal", 1'b1, calibration_enable)
      `CHK("hold", 1'b0, core_reset_hold)
      `CHK("sync", 1'b0, divider_sync_force)
    end
    rchk(4'h3, 16'h0078);
    $display("test prescalers done");
    for (int i = 0; i < 3; i++) begin
      i_host.wr(4'h3, 16'h0060 | (16'h0400 << i) | (16'h0080 << ((i + 1) % 3)));
      @(posedge clock);
      {ev_refsel, ev_refloss, ev_lock} <= 3'(1 << i);
      repeat (2) @(posedge clock);
      #1;
      `CHK("pin_b", 1'b1, status_pin_b)
      `CHK("pin_a", 1'b0, status_pin_a)
      @(posedge clock);
      {ev_refsel, ev_refloss, ev_lock} <= 3'(1 << ((i + 1) % 3));
      repeat (2) @(posedge clock);
      #1;
      `CHK("pin_a", 1'b1, status_pin_a)
      `CHK("pin_b", 1'b0, status_pin_b)
      @(posedge clock);
      {ev_refsel, ev_refloss, ev_lock} <= 3'h0;
    end
    $display("test status done");
    i_host.wr(4'h3, 16'h0000);
    `CHK("hold", 1'b1, core_reset_hold)
    rchk(4'h0, 16'h0355);
    $display("test soft reset done");
    final_report;
  end
endmodule
bind pllcfg_bank pllcfg_assertions i_chk (
  .clock(clock),
  .rst(rst),
  .byte_valid(byte_valid),
  .read_req(read_req),
  .read_addr(read_addr),
  .read_data(read_data),
  .read_valid(read_valid),
  .ev_refsel(ev_refsel),
  .ev_refloss(ev_refloss),
  .ev_lock(ev_lock),
  .loop_cap_select(loop_cap_select),
  .reference_divide_value(reference_divide_value),
  .core_reset_hold(core_reset_hold),
  .divider_sync_force(divider_sync_force),
  .prescaler_feedback_ratio(prescaler_feedback_ratio),
  .status_pin_a(status_pin_a),
  .status_pin_b(status_pin_b)
);
